// [design/srl_pkg.sv]
// Purpose: Shared constants and types for the set/reset latch control block
// Assumes: Classic Wishbone register access, 8-bit registers in word slots
// Notes: Offsets are byte addresses of aligned 32-bit words
package srl_pkg;
  localparam logic [3:0] ADDR_CONTROL_MAIN = 4'h0;
  localparam logic [3:0] ADDR_SOURCE_ENABLES = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Control main fields
  localparam int LATCH_ENABLE_BIT = 7;
  localparam int PULSE_SEL_LSB = 4;
  localparam int TRUE_OE_BIT = 3;
  localparam int INV_OE_BIT = 2;
  localparam int SW_SET_BIT = 1;
  localparam int SW_RESET_BIT = 0;
  // Source enable fields
  localparam int PIN_SET_BIT = 7;
  localparam int CLK_SET_BIT = 6;
  localparam int CMP2_SET_BIT = 5;
  localparam int CMP1_SET_BIT = 4;
  localparam int PIN_RESET_BIT = 3;
  localparam int CLK_RESET_BIT = 2;
  localparam int CMP2_RESET_BIT = 1;
  localparam int CMP1_RESET_BIT = 0;
  localparam logic [7:0] CONTROL_MAIN_RESET = 8'h00;
  localparam logic [7:0] SOURCE_ENABLES_RESET = 8'h00;
  localparam logic [8:0] DIV_COUNT_RESET = 9'h000;
  localparam int DIV_WIDTH = 9;
endpackage : srl_pkg

// [design/srl_if.sv]
// Purpose: Carries pulse select and pulse between top and pulse generator
// Assumes: One clock domain
// Notes: Top drives select, generator drives pulse
`timescale 1ns/10ps
`default_nettype none
interface srl_if;
  logic [2:0] pulse_select;
  logic pulse;
  modport ctrl (output pulse_select, input pulse);
  modport gen (input pulse_select, output pulse);
endinterface : srl_if
`default_nettype wire

// [design/srl_pulse_gen.sv]
// Purpose: Periodic pulse generator, one clock wide every 4 to 512 cycles
// Assumes: SYS_CLK stands for the oscillator clock
// Notes: Free-running counter, selection taken from its low bits
`timescale 1ns/10ps
`default_nettype none
module srl_pulse_gen (
  input wire logic clk,
  input wire logic srst,
  srl_if.gen pg
);
  typedef struct packed {
    logic [srl_pkg::DIV_WIDTH-1:0] cnt;
    logic pulse;
  } srl_pg_state_t;
  srl_pg_state_t s_q, s_d;
  logic [srl_pkg::DIV_WIDTH-1:0] mask;

  always_comb begin
    // Divider 2^(code+2): pulse when the low code+2 bits wrap to zero
    mask = 9'(({1'b0, 9'h1FF} >> (3'd7 - pg.pulse_select)) & 10'h3FF);
    s_d = s_q;
    s_d.cnt = 9'(s_q.cnt + 9'h001);
    s_d.pulse = ((s_q.cnt & mask) == (mask & 9'h1FF)) && 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q.cnt <= srl_pkg::DIV_COUNT_RESET;
      s_q.pulse <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pg.pulse = s_q.pulse;
endmodule : srl_pulse_gen
`default_nettype wire

// [design/srl_latch_ctrl.sv]
// Purpose: Reset-dominant set/reset latch with selectable sources and pin outputs
// Assumes: Comparator outputs and input pin are synchronous to SYS_CLK
// Notes: Latch state has no reset value; registers are classic Wishbone slave
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Pulse every 4..512 cycles per select code
// - Latch enable bit gates the latch
// - True output drives pin when enabled
// - Inverted output drives pin when enabled
// - Writing one pulses set one cycle
// - Writing one pulses reset one cycle
// - Pulse bits self clear, read zero
// - Pin high sets latch when enabled
// - Periodic pulse sets latch when enabled
// - Comparator outputs set latch when enabled
// - Pin high resets latch when enabled
// - Periodic pulse resets latch when enabled
// - Comparator outputs reset latch when enabled
// - All control bits reset to zero
// - Active high inputs, reset dominates
// - Latch state not initialized by reset
module srl_latch_ctrl (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CMP_ONE_OUT,
  input wire logic CMP_TWO_OUT,
  input wire logic LATCH_INPUT_PIN,
  output logic TRUE_OUTPUT_PIN_O,
  output logic TRUE_OUTPUT_PIN_OE_N,
  output logic INVERTED_OUTPUT_PIN_O,
  output logic INVERTED_OUTPUT_PIN_OE_N
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] src;
    logic sw_set;
    logic sw_reset;
    logic ack;
    logic [31:0] rdata;
    logic q;
  } srl_state_t;

  srl_state_t s_q, s_d;
  srl_if pg_bus ();
  logic set_in, reset_in, acc, wr_lane0;

  srl_pulse_gen u_pulse_gen (
    .clk(SYS_CLK),
    .srst(SRST),
    .pg(pg_bus.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Latch input combining
  assign pg_bus.pulse_select = s_q.ctrl[srl_pkg::PULSE_SEL_LSB +: 3];
  always_comb begin
    // A pulse gen toggle on both sides is undefined; reset still wins here
    set_in = s_q.sw_set
      | (s_q.src[srl_pkg::PIN_SET_BIT] & LATCH_INPUT_PIN)
      | (s_q.src[srl_pkg::CLK_SET_BIT] & pg_bus.pulse)
      | (s_q.src[srl_pkg::CMP2_SET_BIT] & CMP_TWO_OUT)
      | (s_q.src[srl_pkg::CMP1_SET_BIT] & CMP_ONE_OUT);
    reset_in = s_q.sw_reset
      | (s_q.src[srl_pkg::PIN_RESET_BIT] & LATCH_INPUT_PIN)
      | (s_q.src[srl_pkg::CLK_RESET_BIT] & pg_bus.pulse)
      | (s_q.src[srl_pkg::CMP2_RESET_BIT] & CMP_TWO_OUT)
      | (s_q.src[srl_pkg::CMP1_RESET_BIT] & CMP_ONE_OUT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  assign acc = WB_CYC_I & WB_STB_I & ~s_q.ack;
  assign wr_lane0 = acc & WB_WE_I & WB_SEL_I[0];

  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.sw_set = 1'b0;
    s_d.sw_reset = 1'b0;
    // Latch runs only while enabled; holds its state otherwise
    if (s_q.ctrl[srl_pkg::LATCH_ENABLE_BIT]) begin
      if (reset_in) begin
        s_d.q = 1'b0;
      end else if (set_in) begin
        s_d.q = 1'b1;
      end
    end
    if (wr_lane0) begin
      unique case (WB_ADR_I)
        srl_pkg::ADDR_CONTROL_MAIN: begin
          s_d.ctrl = {WB_DAT_I[7:2], 2'b00};
          s_d.sw_set = WB_DAT_I[srl_pkg::SW_SET_BIT];
          s_d.sw_reset = WB_DAT_I[srl_pkg::SW_RESET_BIT];
        end
        srl_pkg::ADDR_SOURCE_ENABLES: begin
          s_d.src = WB_DAT_I[7:0];
        end
        default: begin
        end
      endcase
    end
    s_d.rdata = 32'h0000_0000;
    if (acc && !WB_WE_I) begin
      unique case (WB_ADR_I)
        srl_pkg::ADDR_CONTROL_MAIN: s_d.rdata = {24'h000000, s_q.ctrl};
        srl_pkg::ADDR_SOURCE_ENABLES: s_d.rdata = {24'h000000, s_q.src};
        srl_pkg::ADDR_STATUS: s_d.rdata = {31'h0000_0000, s_q.q};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; latch bit deliberately left out of reset
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s_q.ctrl <= srl_pkg::CONTROL_MAIN_RESET;
      s_q.src <= srl_pkg::SOURCE_ENABLES_RESET;
      s_q.sw_set <= 1'b0;
      s_q.sw_reset <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.q <= s_d.q;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.rdata;
  assign TRUE_OUTPUT_PIN_O = s_q.q;
  assign INVERTED_OUTPUT_PIN_O = ~s_q.q;
  assign TRUE_OUTPUT_PIN_OE_N =
    ~(s_q.ctrl[srl_pkg::LATCH_ENABLE_BIT] & s_q.ctrl[srl_pkg::TRUE_OE_BIT]);
  assign INVERTED_OUTPUT_PIN_OE_N =
    ~(s_q.ctrl[srl_pkg::LATCH_ENABLE_BIT] & s_q.ctrl[srl_pkg::INV_OE_BIT]);
endmodule : srl_latch_ctrl
`default_nettype wire

// [verification/srl_far_side.sv]
// Purpose: Far side model: two comparators and the latch input pin
// Assumes: Levels change only just after SYS_CLK rising edges
// Notes: Outputs are registered copies of the bench request
`timescale 1ns/10ps
`default_nettype none
module srl_far_side (
  input wire logic clk,
  input wire logic [2:0] drive,
  output logic cmp_one,
  output logic cmp_two,
  output logic pin
);
  initial {cmp_one, cmp_two, pin} = 3'h0;
  // Registered so the block sees levels synchronous to its own clock
  always @(posedge clk) begin
    {cmp_one, cmp_two, pin} <= drive;
  end
endmodule : srl_far_side
`default_nettype wire

// [verification/srl_monitor.sv]
// Purpose: Port checker for the latch control block
// Assumes: Control register shadowed from accepted bus writes, on the design's own edge
// Notes: Bound to the top module
`timescale 1ns/10ps
`default_nettype none
module srl_monitor (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic TRUE_OUTPUT_PIN_O,
  input wire logic TRUE_OUTPUT_PIN_OE_N,
  input wire logic INVERTED_OUTPUT_PIN_O,
  input wire logic INVERTED_OUTPUT_PIN_OE_N
);
  logic [7:0] ctl_q;
  logic rd;
  logic cm;
  assign rd = WB_ACK_O && !WB_WE_I;
  assign cm = WB_ADR_I == srl_pkg::ADDR_CONTROL_MAIN;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      ctl_q <= 8'h00;
    else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && cm && WB_SEL_I[0])
      ctl_q <= WB_DAT_I[7:0];
  end
  chk_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  chk_pulse_bits_zero: assert property (rd && cm |-> WB_DAT_O[1:0] == 2'h0)
    else $error("pulse bits read nonzero");
  chk_upper_zero: assert property (rd |-> WB_DAT_O[31:8] == 24'h0) else $error("upper data");
  chk_ctl_readback: assert property (rd && cm |-> WB_DAT_O[7:2] == ctl_q[7:2])
    else $error("control readback wrong");
  // Shadow must settle one cycle, so either comb or registered gating passes
  chk_true_gate: assert property ($stable(ctl_q) |-> TRUE_OUTPUT_PIN_OE_N ==
    !(ctl_q[7] && ctl_q[3])) else $error("true pin enable wrong");
  chk_inv_gate: assert property ($stable(ctl_q) |-> INVERTED_OUTPUT_PIN_OE_N ==
    !(ctl_q[7] && ctl_q[2])) else $error("inverted pin enable wrong");
  chk_pin_complement: assert property (!TRUE_OUTPUT_PIN_OE_N && !INVERTED_OUTPUT_PIN_OE_N
    |-> TRUE_OUTPUT_PIN_O != INVERTED_OUTPUT_PIN_O) else $error("pins not complementary");
  cover property (rd && cm);
  cover property (!TRUE_OUTPUT_PIN_OE_N && TRUE_OUTPUT_PIN_O);
  cover property (!INVERTED_OUTPUT_PIN_OE_N && INVERTED_OUTPUT_PIN_O);
endmodule : srl_monitor
bind srl_latch_ctrl srl_monitor mon_u (.SYS_CLK, .SRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .TRUE_OUTPUT_PIN_O,
  .TRUE_OUTPUT_PIN_OE_N, .INVERTED_OUTPUT_PIN_O, .INVERTED_OUTPUT_PIN_OE_N);
`default_nettype wire

// [verification/srl_latch_ctrl_test.sv]
// Purpose: Self-checking bench for the latch control block
// Assumes: Pulse select code 0, so periodic pulses come every 4 cycles, except code 3 (every 32 cycles) in t_period
// Notes: Pins compared as {true, inverted, true oe_n, inverted oe_n}
`timescale 1ns/10ps
`default_nettype none
module srl_latch_ctrl_test;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, rd, dout;
  logic ack, cmp1, cmp2, pin, tq, tq_oe_n, nq, nq_oe_n;
  logic [2:0] drive = 3'h0;
  logic [2:0] srcs [4] = '{3'h1, 3'h0, 3'h2, 3'h4};
  int errors = 0, comparisons = 0, cycles = 0;
  localparam logic [3:0] CM = srl_pkg::ADDR_CONTROL_MAIN;
  localparam logic [3:0] SE = srl_pkg::ADDR_SOURCE_ENABLES;
  always #4 SYS_CLK = ~SYS_CLK;
  srl_far_side far_u (.clk(SYS_CLK), .drive(drive), .cmp_one(cmp1), .cmp_two(cmp2), .pin(pin));
  srl_latch_ctrl dut_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dout),
    .WB_ACK_O(ack), .CMP_ONE_OUT(cmp1), .CMP_TWO_OUT(cmp2), .LATCH_INPUT_PIN(pin),
    .TRUE_OUTPUT_PIN_O(tq), .TRUE_OUTPUT_PIN_OE_N(tq_oe_n), .INVERTED_OUTPUT_PIN_O(nq),
    .INVERTED_OUTPUT_PIN_OE_N(nq_oe_n));
  task results;
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      results();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
    do @(posedge SYS_CLK); while (ack !== 1'b1);
    rd = dout;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task pins(input logic [3:0] e);
    repeat (6) @(posedge SYS_CLK);
    chk({28'h0, tq, nq, tq_oe_n, nq_oe_n}, {28'h0, e});
  endtask : pins
  task t_reset;
    wb(1'b0, CM, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, SE, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, 4'hC, 8'h00);
    chk(rd, 32'h0);
  endtask : t_reset
  task t_soft;
    wb(1'b1, CM, 8'h82);
    wb(1'b1, CM, 8'h8C);
    pins(4'h8);
    wb(1'b0, CM, 8'h00);
    chk(rd, 32'h8C);
    wb(1'b1, CM, 8'h8D);
    pins(4'h4);
    wb(1'b1, CM, 8'h8F);
    pins(4'h4);
    wb(1'b1, CM, 8'h0C);
    wb(1'b1, SE, 8'h80);
    drive <= 3'h1;
    pins(4'h7);
    drive <= 3'h0;
  endtask : t_soft
  task t_sources;
    wb(1'b1, SE, 8'h00);
    wb(1'b1, CM, 8'h8D);
    drive <= 3'h7;
    pins(4'h4);
    drive <= 3'h0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, SE, 8'h80 >> i);
      drive <= srcs[i];
      pins(4'h8);
      drive <= 3'h0;
      wb(1'b1, SE, 8'h08 >> i);
      drive <= srcs[i];
      pins(4'h4);
      drive <= 3'h0;
    end
  endtask : t_sources
  // Divider 32: two set pulses one period apart, then a mid-run reset
  task t_period;
    int t1;
    wb(1'b1, CM, 8'hB9);
    wb(1'b1, SE, 8'h40); // never the same source on both inputs
    while (tq !== 1'b1) @(posedge SYS_CLK);
    t1 = cycles;
    wb(1'b1, CM, 8'hB9);
    while (tq !== 1'b0) @(posedge SYS_CLK);
    while (tq !== 1'b1) @(posedge SYS_CLK);
    chk(cycles - t1, 32'h20);
    SRST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    wb(1'b0, CM, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, SE, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, srl_pkg::ADDR_STATUS, 8'h00);
    chk(rd, 32'h1);
  endtask : t_period
  initial begin
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    t_reset();
    t_soft();
    t_sources();
    t_period();
    results();
  end
endmodule : srl_latch_ctrl_test
`default_nettype wire
